// ### shared/vfrc_pkg.sv
// package of constants for the output-voltage fault response configuration block
`default_nettype none
package vfrc_pkg;
    // command codes of the register bank
    localparam logic [7:0] CMD_CURRENT_SENSE_GAIN = 8'h38;
    localparam logic [7:0] CMD_CURRENT_SENSE_OFFSET = 8'h39;
    localparam logic [7:0] CMD_OVERVOLTAGE_THRESHOLD = 8'h40;
    localparam logic [7:0] CMD_OVERVOLTAGE_RESPONSE = 8'h41;
    localparam logic [7:0] CMD_UNDERVOLTAGE_THRESHOLD = 8'h44;
    localparam logic [7:0] CMD_UNDERVOLTAGE_RESPONSE = 8'h45;
    // reset values
    localparam logic [15:0] RST_CURRENT_SENSE_GAIN = 16'hba2a;
    localparam logic [15:0] RST_CURRENT_SENSE_OFFSET = 16'hbe00;
    localparam logic [7:0] RST_FAULT_RESPONSE = 8'h80;
    // response byte fields
    localparam int RESP_MODE_HI = 7;
    localparam int RESP_MODE_LO = 6;
    localparam int RESP_RETRY_HI = 5;
    localparam int RESP_RETRY_LO = 3;
    localparam int RESP_TIME_HI = 2;
    localparam int RESP_TIME_LO = 0;
    localparam logic [1:0] MODE_IGNORE = 2'h0;
    localparam logic [1:0] MODE_DELAY_OFF = 2'h1;
    localparam logic [1:0] MODE_OFF_RETRY = 2'h2;
    localparam logic [1:0] MODE_OFF_WHILE = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // linear voltage exponent is -13
    localparam int VOUT_EXPONENT = -13;
    // threshold scaling of the strap setpoint: 1.15 = 23/20, 0.85 = 17/20
    localparam int OV_SCALE_NUM = 23;
    localparam int UV_SCALE_NUM = 17;
    localparam int SCALE_DEN = 20;
    // time units per count, in microseconds, and their cycle counts at 100 MHz
    localparam int CLK_MHZ = 100;
    localparam int OV_TIME_UNIT_US = 10;
    localparam int UV_TIME_UNIT_US = 100;
    localparam int OV_UNIT_CYCLES = OV_TIME_UNIT_US * CLK_MHZ;
    localparam int UV_UNIT_CYCLES = UV_TIME_UNIT_US * CLK_MHZ;
    // fault handler states
    typedef enum logic [2:0] {
        VFRC_ST_RUN = 3'b000,
        VFRC_ST_DELAY = 3'b001,
        VFRC_ST_OFF_WAIT = 3'b010,
        VFRC_ST_LATCHED_OFF = 3'b011,
        VFRC_ST_HOLD_OFF = 3'b100
    } vfrc_state_t;
endpackage
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the fault response configuration block
`default_nettype none
module testbench;
    import vfrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] NORM = 16'h2000;
    localparam logic [15:0] OV_HI = 16'h3000;
    localparam logic [15:0] UV_LO = 16'h1000;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_write, cmd_read, cmd_ack, cmd_refused, clear_faults, restart;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, gain, offset;
    logic [15:0] strap_vout = NORM;
    logic [15:0] vout_meas = NORM;
    logic vout_ramping = 1'b0;
    logic output_enabled = 1'b1;
    logic ov_status, uv_status, output_off, retry_pulse;
    logic [15:0] rd;
    logic rf, ak;
    int err_total = 0;
    int comparisons = 0;
    int pulse_count = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    // retry attempts seen at the port
    always @(negedge clk) if (retry_pulse === 1'b1) pulse_count++;

    vfrc_host_model host (.clk(clk), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_refused(cmd_refused),
        .clear_faults(clear_faults), .restart(restart));

    vfrc_top #(.OV_UNIT(4), .UV_UNIT(8)) dut (.clk(clk), .reset_n(reset_n), .cmd_write(cmd_write),
        .cmd_read(cmd_read), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .cmd_ack(cmd_ack), .cmd_refused(cmd_refused), .clear_faults(clear_faults), .restart(restart),
        .strap_vout(strap_vout), .vout_meas(vout_meas), .vout_ramping(vout_ramping),
        .output_enabled(output_enabled), .ov_status(ov_status), .uv_status(uv_status),
        .output_off(output_off), .retry_pulse(retry_pulse), .current_sense_gain_r(gain),
        .current_sense_offset_r(offset));

    // verdict and end of run
    task automatic give_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check16(input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic check1(input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // write with the expected refusal flag
    task automatic wr(input logic [7:0] code, input logic [15:0] data, input logic exp_ref);
        host.access(1'b1, code, data, rd, rf, ak);
        check1(1'b1, ak);
        check1(exp_ref, rf);
    endtask

    task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
        host.access(1'b0, code, 16'h0000, rd, rf, ak);
        check1(1'b1, ak);
        check16(exp, rd);
    endtask

    // back to normal output, restarted and cleared
    task automatic restore();
        vout_meas = NORM;
        cyc(2);
        host.pulse(1'b1);
        host.pulse(1'b0);
        cyc(2);
        check1(1'b0, output_off);
        check1(1'b0, ov_status);
        check1(1'b0, uv_status);
    endtask

    // watchdog well beyond the expected run time
    initial begin
        #100000;
        err_total++;
        give_verdict();
    end

    initial begin
        cyc(6);
        reset_n = 1'b1;
        cyc(2);
        rd_chk(CMD_CURRENT_SENSE_GAIN, 16'hba2a);
        rd_chk(CMD_CURRENT_SENSE_OFFSET, 16'hbe00);
        rd_chk(CMD_OVERVOLTAGE_RESPONSE, 16'h0080);
        rd_chk(CMD_UNDERVOLTAGE_RESPONSE, 16'h0080);
        // strap 2000 is 1.0 V with exponent -13, scaled and truncated
        rd_chk(CMD_OVERVOLTAGE_THRESHOLD, 16'h24cc);
        rd_chk(CMD_UNDERVOLTAGE_THRESHOLD, 16'h1b33);
        wr(CMD_CURRENT_SENSE_GAIN, 16'h1234, 1'b0);
        wr(CMD_CURRENT_SENSE_OFFSET, 16'hc001, 1'b0);
        check16(16'h1234, gain);
        check16(16'hc001, offset);
        rd_chk(CMD_CURRENT_SENSE_OFFSET, 16'hc001);
        wr(CMD_OVERVOLTAGE_THRESHOLD, 16'h2800, 1'b0);
        wr(CMD_UNDERVOLTAGE_THRESHOLD, 16'h1800, 1'b0);
        rd_chk(CMD_OVERVOLTAGE_THRESHOLD, 16'h2800);
        rd_chk(8'h42, 16'h0000);
        wr(CMD_OVERVOLTAGE_RESPONSE, 16'h0000, 1'b1);
        rd_chk(CMD_OVERVOLTAGE_RESPONSE, 16'h0080);
        wr(CMD_UNDERVOLTAGE_RESPONSE, 16'h0000, 1'b0);
        rd_chk(CMD_UNDERVOLTAGE_RESPONSE, 16'h0000);
        // equal to threshold is no fault
        vout_meas = 16'h2800;
        cyc(4);
        check1(1'b0, ov_status);
        vout_meas = UV_LO;
        cyc(3);
        check1(1'b1, uv_status);
        check1(1'b0, output_off);
        restore();
        vout_meas = OV_HI;
        cyc(2);
        check1(1'b1, output_off);
        check1(1'b1, ov_status);
        host.pulse(1'b0);
        cyc(2);
        check1(1'b1, ov_status);
        vout_meas = NORM;
        cyc(20);
        check1(1'b1, output_off);
        host.pulse(1'b0);
        cyc(1);
        check1(1'b0, ov_status);
        check1(1'b1, output_off);
        restore();
        // delayed off, overvoltage unit 4 cycles
        wr(CMD_OVERVOLTAGE_RESPONSE, 16'h0042, 1'b0);
        vout_meas = OV_HI;
        cyc(6);
        check1(1'b0, output_off);
        cyc(10);
        check1(1'b1, output_off);
        restore();
        // undervoltage masked while disabled or ramping
        wr(CMD_UNDERVOLTAGE_RESPONSE, 16'h0080, 1'b0);
        output_enabled = 1'b0;
        vout_meas = UV_LO;
        cyc(5);
        check1(1'b0, uv_status);
        output_enabled = 1'b1;
        vout_ramping = 1'b1;
        cyc(5);
        check1(1'b0, uv_status);
        vout_ramping = 1'b0;
        cyc(3);
        check1(1'b1, uv_status);
        check1(1'b1, output_off);
        restore();
        wr(CMD_UNDERVOLTAGE_RESPONSE, 16'h0042, 1'b0);
        vout_meas = UV_LO;
        cyc(16);
        check1(1'b0, output_off);
        cyc(12);
        check1(1'b1, output_off);
        restore();
        // bounded retries at both ends of the range
        for (int n = 1; n <= 6; n += 5) begin
            wr(CMD_OVERVOLTAGE_RESPONSE, {8'h00, 2'b10, 3'(n), 3'b000}, 1'b0);
            pulse_count = 0;
            vout_meas = OV_HI;
            cyc(150);
            check16(16'(n), 16'(pulse_count));
            check1(1'b1, output_off);
            restore();
        end
        // endless retries while the fault stays
        wr(CMD_OVERVOLTAGE_RESPONSE, 16'h00b8, 1'b0);
        pulse_count = 0;
        vout_meas = OV_HI;
        cyc(150);
        check1(1'b1, pulse_count > 10);
        restore();
        // off only while the fault lasts
        wr(CMD_OVERVOLTAGE_RESPONSE, 16'h00c0, 1'b0);
        vout_meas = OV_HI;
        cyc(2);
        check1(1'b1, output_off);
        vout_meas = NORM;
        cyc(2);
        check1(1'b0, output_off);
        check1(1'b1, ov_status);
        restore();
        // second reset with a new strap setpoint reloads thresholds and responses
        strap_vout = 16'h4000;
        vout_meas = 16'h4000;
        reset_n = 1'b0;
        cyc(2);
        reset_n = 1'b1;
        cyc(2);
        rd_chk(CMD_OVERVOLTAGE_THRESHOLD, 16'h4999);
        rd_chk(CMD_UNDERVOLTAGE_THRESHOLD, 16'h3666);
        rd_chk(CMD_OVERVOLTAGE_RESPONSE, 16'h0080);
        check1(1'b0, output_off);
        check1(1'b0, uv_status);
        give_verdict();
    end
endmodule // testbench
`default_nettype wire

// ### test/vfrc_host_model.sv
// host-side model driving the command port and the clear and restart pulses
`default_nettype none
module vfrc_host_model (
    // clock
    input wire logic clk,
    // command port
    output logic cmd_write,
    output logic cmd_read,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    input wire logic [15:0] cmd_rdata,
    input wire logic cmd_ack,
    input wire logic cmd_refused,
    // control pulses
    output logic clear_faults,
    output logic restart
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle levels from time zero
    initial begin
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        clear_faults = 1'b0;
        restart = 1'b0;
    end

    // one strobe cycle, answer taken while ack is up, then lines scrambled
    task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data,
                          output logic [15:0] rd, output logic refused, output logic acked);
        @(negedge clk);
        cmd_write = wr;
        cmd_read = !wr;
        cmd_code = code;
        cmd_wdata = data;
        @(negedge clk);
        acked = cmd_ack;
        rd = cmd_rdata;
        refused = cmd_refused;
        cmd_write = 1'b0;
        cmd_read = 1'b0;
        cmd_code = ~code;
        cmd_wdata = ~data;
    endtask

    // one-cycle pulse: sel high restarts, low clears faults
    task automatic pulse(input logic sel);
        @(negedge clk);
        restart = sel;
        clear_faults = !sel;
        @(negedge clk);
        restart = 1'b0;
        clear_faults = 1'b0;
    endtask
endmodule // vfrc_host_model
`default_nettype wire

// ### verilog/vfrc_fault_handler.sv
// one fault channel: delay, shutdown and restart sequencing
`default_nettype none
module vfrc_fault_handler
    import vfrc_pkg::*;
#(
    parameter int UNIT_CYCLES = 1000
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic [7:0] response,
    input wire logic fault,
    input wire logic restart,
    input wire logic other_shutdown,
    // results
    output logic out_off,
    output logic retry_pulse
);
    localparam int UW = $clog2(UNIT_CYCLES + 1);
    vfrc_state_t state_r;
    logic [UW-1:0] unit_r;
    logic [2:0] count_r;
    logic [2:0] retries_r;
    logic [1:0] mode;
    logic [2:0] retry_set;
    logic [2:0] time_set;
    logic tick;
    logic timer_done;

    assign mode = response[RESP_MODE_HI:RESP_MODE_LO];
    assign retry_set = response[RESP_RETRY_HI:RESP_RETRY_LO];
    assign time_set = response[RESP_TIME_HI:RESP_TIME_LO];
    assign tick = (unit_r == UW'(UNIT_CYCLES - 1));
    assign timer_done = tick && (count_r >= time_set);
    assign out_off = (state_r != VFRC_ST_RUN) && (state_r != VFRC_ST_DELAY);

    // time-count timer, held at zero in VFRC_ST_RUN and restarted each time a count completes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            unit_r <= '0;
            count_r <= '0;
        end else if (state_r == VFRC_ST_RUN || timer_done) begin
            unit_r <= '0;
            count_r <= '0;
        end else if (tick) begin
            unit_r <= '0;
            count_r <= count_r + 3'h1;
        end else begin
            unit_r <= unit_r + UW'(1);
        end
    end

    // state sequencing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= VFRC_ST_RUN;
            retries_r <= '0;
            retry_pulse <= 1'b0;
        end else begin
            retry_pulse <= 1'b0;
            case (state_r)
                VFRC_ST_RUN: begin
                    // attempt count survives a retry that meets the fault again
                    if (!fault) begin
                        retries_r <= '0;
                    end
                    if (fault) begin
                        case (mode)
                            MODE_DELAY_OFF: state_r <= VFRC_ST_DELAY;
                            MODE_OFF_RETRY: state_r <= (retry_set == RETRY_NONE) ? VFRC_ST_LATCHED_OFF
                                                                                 : VFRC_ST_OFF_WAIT;
                            MODE_OFF_WHILE: state_r <= VFRC_ST_HOLD_OFF;
                            default: state_r <= VFRC_ST_RUN;
                        endcase
                    end
                end
                VFRC_ST_DELAY: begin
                    if (!fault) begin
                        state_r <= VFRC_ST_RUN;
                    end else if (timer_done) begin
                        state_r <= (retry_set == RETRY_NONE) ? VFRC_ST_LATCHED_OFF : VFRC_ST_OFF_WAIT;
                    end
                end
                VFRC_ST_OFF_WAIT: begin
                    if (other_shutdown) begin
                        state_r <= VFRC_ST_LATCHED_OFF;
                    end else if (timer_done) begin
                        if (retry_set != RETRY_FOREVER && retries_r >= retry_set) begin
                            state_r <= VFRC_ST_LATCHED_OFF;
                        end else begin
                            retry_pulse <= 1'b1;
                            state_r <= VFRC_ST_RUN;
                            if (retry_set != RETRY_FOREVER) begin
                                retries_r <= retries_r + 3'h1;
                            end
                        end
                    end
                end
                VFRC_ST_LATCHED_OFF: begin
                    if (restart) begin
                        state_r <= VFRC_ST_RUN;
                        retries_r <= '0;
                    end
                end
                VFRC_ST_HOLD_OFF: begin
                    if (!fault) begin
                        state_r <= VFRC_ST_RUN;
                    end
                end
                default: state_r <= VFRC_ST_RUN;
            endcase
        end
    end

    property p_immediate_off;
        @(posedge clk) disable iff (!reset_n)
        (state_r == VFRC_ST_RUN && fault && mode == MODE_OFF_RETRY) |=> out_off;
    endproperty
    a_immediate_off: assert property (p_immediate_off) else $error("immediate off missing");

    property p_hold_release;
        @(posedge clk) disable iff (!reset_n)
        (state_r == VFRC_ST_HOLD_OFF && !fault) |=> !out_off;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold-off not released");

    property p_delay_on;
        @(posedge clk) disable iff (!reset_n)
        (state_r == VFRC_ST_RUN && fault && mode == MODE_DELAY_OFF) |=> !out_off [*2];
    endproperty
    a_delay_on: assert property (p_delay_on) else $error("delay mode shut off early");

    property p_latched;
        @(posedge clk) disable iff (!reset_n)
        (state_r == VFRC_ST_LATCHED_OFF && !restart) |=> out_off;
    endproperty
    a_latched: assert property (p_latched) else $error("latched off released");

    c_hold: cover property (@(posedge clk) disable iff (!reset_n) state_r == VFRC_ST_HOLD_OFF);
    c_retry: cover property (@(posedge clk) disable iff (!reset_n) retry_pulse);
endmodule // vfrc_fault_handler
`default_nettype wire

// ### verilog/vfrc_top.sv
// output-voltage fault thresholds, responses and current-sense calibration bank
`default_nettype none
module vfrc_top
    import vfrc_pkg::*;
#(
    parameter int OV_UNIT = OV_UNIT_CYCLES,
    parameter int UV_UNIT = UV_UNIT_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // command port, one access per strobe
    input wire logic cmd_write,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_code,
    input wire logic [15:0] cmd_wdata,
    output logic [15:0] cmd_rdata,
    output logic cmd_ack,
    output logic cmd_refused,
    // clear faults command and restart
    input wire logic clear_faults,
    input wire logic restart,
    // power stage status
    input wire logic [15:0] strap_vout,
    input wire logic [15:0] vout_meas,
    input wire logic vout_ramping,
    input wire logic output_enabled,
    // fault outputs
    output logic ov_status,
    output logic uv_status,
    output logic output_off,
    output logic retry_pulse,
    // calibration values to current sensing
    output logic [15:0] current_sense_gain_r,
    output logic [15:0] current_sense_offset_r
);
    logic [15:0] overvoltage_threshold_r;
    logic [15:0] undervoltage_threshold_r;
    logic [7:0] overvoltage_response_r;
    logic [7:0] undervoltage_response_r;
    logic strap_loaded_r;
    logic ov_detect;
    logic uv_detect;
    logic ov_off;
    logic uv_off;
    logic ov_retry;
    logic uv_retry;
    logic ov_bad_write;
    logic [21:0] ov_scaled;
    logic [21:0] uv_scaled;

    // strap scaling, exponent -13 kept unchanged
    assign ov_scaled = 22'((22'(strap_vout) * 22'(OV_SCALE_NUM)) / 22'(SCALE_DEN));
    assign uv_scaled = 22'((22'(strap_vout) * 22'(UV_SCALE_NUM)) / 22'(SCALE_DEN));

    assign ov_bad_write = cmd_write && cmd_code == CMD_OVERVOLTAGE_RESPONSE
                          && cmd_wdata[RESP_MODE_HI:RESP_MODE_LO] == MODE_IGNORE;

    // register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            current_sense_gain_r <= RST_CURRENT_SENSE_GAIN;
            current_sense_offset_r <= RST_CURRENT_SENSE_OFFSET;
            overvoltage_response_r <= RST_FAULT_RESPONSE;
            undervoltage_response_r <= RST_FAULT_RESPONSE;
            overvoltage_threshold_r <= '0;
            undervoltage_threshold_r <= '0;
            strap_loaded_r <= 1'b0;
        end else if (!strap_loaded_r) begin
            overvoltage_threshold_r <= (ov_scaled > 22'h00ffff) ? 16'hffff : ov_scaled[15:0];
            undervoltage_threshold_r <= uv_scaled[15:0];
            strap_loaded_r <= 1'b1;
        end else if (cmd_write) begin
            case (cmd_code)
                CMD_CURRENT_SENSE_GAIN: current_sense_gain_r <= cmd_wdata;
                CMD_CURRENT_SENSE_OFFSET: current_sense_offset_r <= cmd_wdata;
                CMD_OVERVOLTAGE_THRESHOLD: overvoltage_threshold_r <= cmd_wdata;
                CMD_OVERVOLTAGE_RESPONSE: begin
                    if (!ov_bad_write) begin
                        overvoltage_response_r <= cmd_wdata[7:0];
                    end
                end
                CMD_UNDERVOLTAGE_THRESHOLD: undervoltage_threshold_r <= cmd_wdata;
                CMD_UNDERVOLTAGE_RESPONSE: undervoltage_response_r <= cmd_wdata[7:0];
                default: ;
            endcase
        end
    end

    // read data and answer strobes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_rdata <= '0;
            cmd_ack <= 1'b0;
            cmd_refused <= 1'b0;
        end else begin
            cmd_ack <= cmd_write || cmd_read;
            cmd_refused <= ov_bad_write;
            if (cmd_read) begin
                case (cmd_code)
                    CMD_CURRENT_SENSE_GAIN: cmd_rdata <= current_sense_gain_r;
                    CMD_CURRENT_SENSE_OFFSET: cmd_rdata <= current_sense_offset_r;
                    CMD_OVERVOLTAGE_THRESHOLD: cmd_rdata <= overvoltage_threshold_r;
                    CMD_OVERVOLTAGE_RESPONSE: cmd_rdata <= {8'h00, overvoltage_response_r};
                    CMD_UNDERVOLTAGE_THRESHOLD: cmd_rdata <= undervoltage_threshold_r;
                    CMD_UNDERVOLTAGE_RESPONSE: cmd_rdata <= {8'h00, undervoltage_response_r};
                    default: cmd_rdata <= 16'h0000;
                endcase
            end
        end
    end

    assign ov_detect = strap_loaded_r && (vout_meas > overvoltage_threshold_r);
    // UV masked in ramp or off
    assign uv_detect = strap_loaded_r && !vout_ramping && output_enabled && !output_off
                       && (vout_meas < undervoltage_threshold_r);

    // sticky status, set wins over clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ov_status <= 1'b0;
            uv_status <= 1'b0;
        end else begin
            ov_status <= ov_detect || (ov_status && !clear_faults);
            uv_status <= uv_detect || (uv_status && !clear_faults);
        end
    end

    // separate time units per fault type
    vfrc_fault_handler #(.UNIT_CYCLES(OV_UNIT)) u_ov (
        .clk(clk),
        .reset_n(reset_n),
        .response(overvoltage_response_r),
        .fault(ov_detect),
        .restart(restart),
        .other_shutdown(uv_off),
        .out_off(ov_off),
        .retry_pulse(ov_retry)
    );
    vfrc_fault_handler #(.UNIT_CYCLES(UV_UNIT)) u_uv (
        .clk(clk),
        .reset_n(reset_n),
        .response(undervoltage_response_r),
        .fault(uv_detect),
        .restart(restart),
        .other_shutdown(ov_off),
        .out_off(uv_off),
        .retry_pulse(uv_retry)
    );

    // clear-faults never restarts; a latched-off channel needs the restart input
    assign output_off = ov_off || uv_off;
    assign retry_pulse = ov_retry || uv_retry;

    property p_ov_refuse;
        @(posedge clk) disable iff (!reset_n)
        (strap_loaded_r && ov_bad_write) |=> (overvoltage_response_r == $past(overvoltage_response_r)) && cmd_refused;
    endproperty
    a_ov_refuse: assert property (p_ov_refuse) else $error("ignore mode accepted");

    property p_sticky;
        @(posedge clk) disable iff (!reset_n)
        (ov_status && !clear_faults) |=> ov_status;
    endproperty
    a_sticky: assert property (p_sticky) else $error("fault bit dropped");

    property p_set_wins;
        @(posedge clk) disable iff (!reset_n)
        (clear_faults && ov_detect) |=> ov_status;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("live fault lost on clear");

    property p_uv_mask;
        @(posedge clk) disable iff (!reset_n)
        (vout_ramping || !output_enabled) |-> !uv_detect;
    endproperty
    a_uv_mask: assert property (p_uv_mask) else $error("uv not masked");

    property p_gain_rw;
        @(posedge clk) disable iff (!reset_n)
        (strap_loaded_r && cmd_write && cmd_code == CMD_CURRENT_SENSE_GAIN) |=> current_sense_gain_r == $past(cmd_wdata);
    endproperty
    a_gain_rw: assert property (p_gain_rw) else $error("gain write lost");

    property p_ack;
        @(posedge clk) disable iff (!reset_n)
        (cmd_read || cmd_write) |=> cmd_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("no answer");

    c_ov_fault: cover property (@(posedge clk) disable iff (!reset_n) $rose(ov_status));
    c_uv_fault: cover property (@(posedge clk) disable iff (!reset_n) $rose(uv_status));
    c_refuse: cover property (@(posedge clk) disable iff (!reset_n) cmd_refused);
endmodule // vfrc_top
`default_nettype wire
